// file: verilog/dpg_consts.vh
// Constants for the playback gain and limiter path: register indexes, field positions,
// reset values and timing figures.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef DPG_CONSTS_VH
`define DPG_CONSTS_VH

// Register indexes; byte address is four times the index
`define DPG_IDX_POWER 6'h03
`define DPG_IDX_CTRL 6'h0A
`define DPG_IDX_LEVEL 6'h0B
`define DPG_IDX_LIM_A 6'h18
`define DPG_IDX_LIM_B 6'h19
`define DPG_IDX_STATUS 6'h1F

// Reset values
`define DPG_RST_POWER 9'h000
`define DPG_RST_CTRL 9'h000
`define DPG_RST_LEVEL 9'h0FF
`define DPG_RST_LIM_A 9'h032
`define DPG_RST_LIM_B 9'h000

// Field positions
`define DPG_POWER_EN_BIT 0
`define DPG_CTRL_SILENCE_BIT 6
`define DPG_CTRL_ZRUN_BIT 2
`define DPG_CTRL_INVERT_BIT 0
`define DPG_LEVEL_RANGE 7:0
`define DPG_LIM_EN_BIT 8
`define DPG_LIM_DCY_RANGE 7:4
`define DPG_LIM_ATK_RANGE 3:0
`define DPG_LIM_THR_RANGE 6:4
`define DPG_LIM_BOOST_RANGE 3:0

// Gain arithmetic
`define DPG_BOOST_MAX 4'hC
`define DPG_THR_SEL_MAX 3'h5
`define DPG_SOFT_MAX 8'hFF
`define DPG_LIM_ATT_MAX 7'h48
`define DPG_HEADROOM 10'h018
`define DPG_STEPS_PER_6DB 12
`define DPG_FRAC_BITS 13
`define DPG_PROD_W 41
`define DPG_FULL_POS 24'h7F_FFFF
`define DPG_FULL_NEG 24'h80_0000

// Zero run length before the automatic mute
`define DPG_ZERO_RUN 11'h400

// Limiter timing: times in microseconds at the reference sample rate
`define DPG_REF_RATE_HZ 44100
`define DPG_US_PER_S 1000000
`define DPG_ATK_BASE_US 94
`define DPG_DCY_BASE_US 750
`define DPG_RATE_CODE_MAX 4'hB

// Oversampling: clock divider and interpolator smoothing shift
`define DPG_OSR_DIV 8'h28
`define DPG_INTERP_SHIFT 4
`define DPG_SD_FRAC 20

`endif

// file: verilog/dpg_playback_gain_limiter.v
// Playback digital path: volume, soft silence, peak limiter with lift gain, automute,
// polarity, 24-bit interpolation and a multi-bit first-order sigma-delta modulator.
// Assumes samples arrive as parallel 24-bit words with a one-cycle valid from the
// audio interface on the same clock, and an APB3 master on the register side.
//
// Summary of operation
// - Power bit enables filters and converter together.
// - Samples come from the playback input, then volume and limiter, then modulator.
// - Level code X gives 0.5*(X-255) dB; code zero silences output.
// - Level field bits 7:0 resets to all ones, unity gain.
// - Soft silence bit 6 ramps gain to zero; clearing steps back up.
// - Interpolation at 24-bit precision feeding a multi-bit sigma-delta bitstream.
// - Output non-inverted by default; invert control flips polarity.
// - With automute on, mute after 1024 zero samples; release on non-zero.
// - Automute enable is control bit 2, reset zero.
// - Limiter enable is bit 8 of limiter register A, reset zero.
// - Above upper threshold, reduce gain at attack rate; stop when below.
// - Below lower threshold, raise gain at decay rate up to target gain.
// - Upper threshold 0.5dB above level, lower 0.5dB below.
// - Threshold field bits 6:4 reset 000; -1dB to -5dB, then -6dB.
// - Decay bits 7:4 reset 0011; 750us doubling to 1.536s per 6dB.
// - Attack bits 3:0 reset 0010; 94us doubling to 192ms per 6dB.
// - Lift gain 0dB to +12dB in 1dB steps; codes above twelve reserved.
// - With limiter off, lift gain still applies as fixed boost.
`timescale 1ns/1ps
`include "dpg_consts.vh"

module dpg_playback_gain_limiter
(
	input wire clock,
	input wire rst,
	input wire [7:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [23:0] playbackSerialIn,
	input wire playbackSerialValid,
	output wire [3:0] modCode,
	output wire modStrobe,
	output wire analogMute,
	output wire converterActive
);

	localparam integer ATK_BASE_I = (`DPG_ATK_BASE_US * `DPG_REF_RATE_HZ) / `DPG_US_PER_S;
	localparam integer DCY_BASE_I = (`DPG_DCY_BASE_US * `DPG_REF_RATE_HZ) / `DPG_US_PER_S;
	localparam integer STEPS_I = `DPG_STEPS_PER_6DB;
	localparam [16:0] ATK_BASE = ATK_BASE_I[16:0];
	localparam [16:0] DCY_BASE = DCY_BASE_I[16:0];
	localparam [17:0] STEP_INC = STEPS_I[17:0];

	////////////////////////////////////////////////////////////////////////////
	// Helper functions

	// Q15 gain of one 0.5dB step position inside a 6dB octave
	function [15:0] mantissa;
		input [3:0] k;
		begin
			case (k)
				4'h0: mantissa = 16'h8000;
				4'h1: mantissa = 16'h78D7;
				4'h2: mantissa = 16'h7215;
				4'h3: mantissa = 16'h6BB3;
				4'h4: mantissa = 16'h65AD;
				4'h5: mantissa = 16'h5FFD;
				4'h6: mantissa = 16'h5A9E;
				4'h7: mantissa = 16'h558C;
				4'h8: mantissa = 16'h50C3;
				4'h9: mantissa = 16'h4C3F;
				4'hA: mantissa = 16'h47FB;
				4'hB: mantissa = 16'h43F4;
				default: mantissa = 16'h8000;
			endcase
		end
	endfunction

	// Full-scale magnitude attenuated by idx half-dB steps, idx below 16
	function [23:0] threshLevel;
		input [3:0] idx;
		begin
			if (idx < `DPG_STEPS_PER_6DB)
				threshLevel = {mantissa(idx), 8'h00};
			else
				threshLevel = {1'b0, mantissa(idx - 4'hC), 7'h00};
		end
	endfunction

	// Fractional step accumulator: returns step flag and next accumulator
	function [17:0] stepAcc;
		input [16:0] acc;
		input [16:0] period;
		reg [17:0] sum;
		begin
			sum = {1'b0, acc} + STEP_INC;
			if (sum >= {1'b0, period})
				stepAcc = {1'b1, sum[16:0] - period};
			else
				stepAcc = {1'b0, sum[16:0]};
		end
	endfunction

	// Samples per 6dB for a rate code, doubling per code up to the cap
	function [16:0] ratePeriod;
		input [16:0] base;
		input [3:0] code;
		reg [3:0] c;
		begin
			c = (code > `DPG_RATE_CODE_MAX) ? `DPG_RATE_CODE_MAX : code;
			ratePeriod = base << c;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Register file and APB slave

	reg [8:0] powerReg_reg;
	reg [8:0] ctrlReg_reg;
	reg [8:0] levelReg_reg;
	reg [8:0] limA_reg;
	reg [8:0] limB_reg;
	reg [31:0] prdata_reg;
	reg pready_reg;
	reg pslverr_reg;
	reg [31:0] readData;
	reg addrHit;
	reg [7:0] softAtt_reg;
	reg [6:0] limAtt_reg;
	reg [10:0] zeroRun_reg;

	wire [5:0] regIdx = paddr[7:2];
	wire apbAccess = psel & penable & ~pready_reg;
	// Completing edge of a transfer: writes commit only here
	wire apbDone = psel & penable & pready_reg;

	// Read mux and address decode
	always @*
	begin
		readData = 32'h0000_0000;
		addrHit = (paddr[1:0] == 2'b00);
		case (regIdx)
			`DPG_IDX_POWER: readData = {23'h00_0000, powerReg_reg};
			`DPG_IDX_CTRL: readData = {23'h00_0000, ctrlReg_reg};
			`DPG_IDX_LEVEL: readData = {23'h00_0000, levelReg_reg};
			`DPG_IDX_LIM_A: readData = {23'h00_0000, limA_reg};
			`DPG_IDX_LIM_B: readData = {23'h00_0000, limB_reg};
			`DPG_IDX_STATUS: readData = {8'h00, softAtt_reg, 1'b0, limAtt_reg, 7'h00, analogMute};
			default: addrHit = 1'b0;
		endcase
	end

	// Registers, one wait state per access: pready rises in the second access cycle
	always @(posedge clock)
	begin
		if (rst)
		begin
			powerReg_reg <= `DPG_RST_POWER;
			ctrlReg_reg <= `DPG_RST_CTRL;
			levelReg_reg <= `DPG_RST_LEVEL;
			limA_reg <= `DPG_RST_LIM_A;
			limB_reg <= `DPG_RST_LIM_B;
			prdata_reg <= 32'h0000_0000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end
		else
		begin
			pready_reg <= apbAccess;
			pslverr_reg <= apbAccess & ~addrHit;
			prdata_reg <= (apbAccess & ~pwrite & addrHit) ? readData : 32'h0000_0000;
			if (apbDone & pwrite & addrHit)
			begin
				case (regIdx)
					`DPG_IDX_POWER: powerReg_reg <= pwdata[8:0];
					`DPG_IDX_CTRL: ctrlReg_reg <= pwdata[8:0];
					`DPG_IDX_LEVEL: levelReg_reg <= pwdata[8:0];
					`DPG_IDX_LIM_A: limA_reg <= pwdata[8:0];
					`DPG_IDX_LIM_B: limB_reg <= pwdata[8:0];
					default: powerReg_reg <= powerReg_reg;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Field decode

	wire powerOn = powerReg_reg[`DPG_POWER_EN_BIT];
	wire softSilence = ctrlReg_reg[`DPG_CTRL_SILENCE_BIT];
	wire zeroRunEn = ctrlReg_reg[`DPG_CTRL_ZRUN_BIT];
	wire phaseInvert = ctrlReg_reg[`DPG_CTRL_INVERT_BIT];
	wire [7:0] levelCode = levelReg_reg[`DPG_LEVEL_RANGE];
	wire limOn = limA_reg[`DPG_LIM_EN_BIT];
	wire [3:0] releaseRate = limA_reg[`DPG_LIM_DCY_RANGE];
	wire [3:0] onsetRate = limA_reg[`DPG_LIM_ATK_RANGE];
	wire [2:0] thrSelRaw = limB_reg[`DPG_LIM_THR_RANGE];
	wire [3:0] liftRaw = limB_reg[`DPG_LIM_BOOST_RANGE];

	// Reserved lift codes clamp to the top step; threshold codes above five share -6dB
	wire [3:0] liftGain = (liftRaw > `DPG_BOOST_MAX) ? `DPG_BOOST_MAX : liftRaw;
	wire [2:0] thrSel = (thrSelRaw > `DPG_THR_SEL_MAX) ? `DPG_THR_SEL_MAX : thrSelRaw;
	// Upper sits at level +0.5dB, lower at level -0.5dB, in half-dB steps
	wire [23:0] upperThr = threshLevel({thrSel, 1'b0} + 4'h1);
	wire [23:0] lowerThr = threshLevel({thrSel, 1'b0} + 4'h3);
	wire [16:0] onsetPeriod = ratePeriod(ATK_BASE, onsetRate);
	wire [16:0] releasePeriod = ratePeriod(DCY_BASE, releaseRate);

	////////////////////////////////////////////////////////////////////////////
	// Gain stage

	// Total attenuation in half-dB, offset by headroom so the full lift stays positive
	wire [9:0] attIdx = {2'b00, ~levelCode} + {2'b00, softAtt_reg} + {3'b000, limAtt_reg}
		+ `DPG_HEADROOM - {5'b00000, liftGain, 1'b0};
	wire [31:0] octaveWide = attIdx / `DPG_STEPS_PER_6DB;
	wire [31:0] stepWide = attIdx - octaveWide * `DPG_STEPS_PER_6DB;
	wire [31:0] shiftWide = octaveWide + `DPG_FRAC_BITS;
	wire [3:0] stepPos = stepWide[3:0];
	wire [6:0] shiftAmt = shiftWide[6:0];
	wire signed [23:0] sampleIn = playbackSerialIn;
	wire signed [16:0] gainMul = {1'b0, mantissa(stepPos)};
	wire signed [40:0] product = sampleIn * gainMul;
	wire signed [40:0] shifted = (shiftAmt >= `DPG_PROD_W) ? 41'sd0 : (product >>> shiftAmt);

	reg signed [23:0] gainSample;
	reg [23:0] peakMag;

	// Saturate the gained sample and take its magnitude for the limiter detector
	always @*
	begin
		gainSample = shifted[23:0];
		if (shifted > $signed({17'h0_0000, `DPG_FULL_POS}))
			gainSample = `DPG_FULL_POS;
		else if (shifted < $signed({17'h1_FFFF, `DPG_FULL_NEG}))
			gainSample = `DPG_FULL_NEG;
		peakMag = gainSample[23] ? (24'h00_0000 - gainSample) : gainSample;
	end

	////////////////////////////////////////////////////////////////////////////
	// Automute, soft silence, limiter and output sample

	reg [16:0] onsetAcc_reg;
	reg [16:0] releaseAcc_reg;
	reg signed [23:0] target_reg;
	reg analogMute_reg;

	wire muteNow = zeroRunEn & (sampleIn == 24'sd0) & (zeroRun_reg >= `DPG_ZERO_RUN - 11'h001);
	wire silenced = (levelCode == 8'h00) | (softAtt_reg == `DPG_SOFT_MAX) | muteNow;
	wire [17:0] onsetStep = stepAcc(onsetAcc_reg, onsetPeriod);
	wire [17:0] releaseStep = stepAcc(releaseAcc_reg, releasePeriod);
	wire signed [23:0] polSample = phaseInvert ?
		((gainSample == `DPG_FULL_NEG) ? `DPG_FULL_POS : -gainSample) : gainSample;

	// Per-sample state: zero-run count, silence ramp, limiter attenuation
	always @(posedge clock)
	begin
		if (rst | ~powerOn)
		begin
			zeroRun_reg <= 11'h000;
			softAtt_reg <= 8'h00;
			limAtt_reg <= 7'h00;
			onsetAcc_reg <= 17'h0_0000;
			releaseAcc_reg <= 17'h0_0000;
			target_reg <= 24'sd0;
			analogMute_reg <= 1'b0;
		end
		else if (playbackSerialValid)
		begin
			// First non-zero sample releases the mute at once
			if (sampleIn != 24'sd0)
				zeroRun_reg <= 11'h000;
			else if (zeroRun_reg < `DPG_ZERO_RUN)
				zeroRun_reg <= zeroRun_reg + 11'h001;
			analogMute_reg <= muteNow;
			// One half-dB step per sample toward silence or back
			if (softSilence && softAtt_reg != `DPG_SOFT_MAX)
				softAtt_reg <= softAtt_reg + 8'h01;
			else if (!softSilence && softAtt_reg != 8'h00)
				softAtt_reg <= softAtt_reg - 8'h01;
			// Limiter: attack above upper, decay below lower, hold in between
			if (!limOn)
			begin
				limAtt_reg <= 7'h00;
				onsetAcc_reg <= 17'h0_0000;
				releaseAcc_reg <= 17'h0_0000;
			end
			else if (peakMag > upperThr)
			begin
				onsetAcc_reg <= onsetStep[16:0];
				releaseAcc_reg <= 17'h0_0000;
				if (onsetStep[17] && limAtt_reg != `DPG_LIM_ATT_MAX)
					limAtt_reg <= limAtt_reg + 7'h01;
			end
			else if (peakMag < lowerThr)
			begin
				releaseAcc_reg <= releaseStep[16:0];
				onsetAcc_reg <= 17'h0_0000;
				if (releaseStep[17] && limAtt_reg != 7'h00)
					limAtt_reg <= limAtt_reg - 7'h01;
			end
			else
			begin
				onsetAcc_reg <= 17'h0_0000;
				releaseAcc_reg <= 17'h0_0000;
			end
			target_reg <= silenced ? 24'sd0 : polSample;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Oversampling tick, interpolator and sigma-delta modulator

	reg [7:0] osrCount_reg;
	reg osrTick_reg;
	reg signed [23:0] interp_reg;
	reg [19:0] sdErr_reg;
	reg [3:0] modCode_reg;
	reg modStrobe_reg;
	reg converterActive_reg;

	wire signed [24:0] interpDiff = {target_reg[23], target_reg} - {interp_reg[23], interp_reg};
	wire signed [24:0] interpStep = interpDiff >>> `DPG_INTERP_SHIFT;
	wire signed [24:0] interpSum = {interp_reg[23], interp_reg} + interpStep;
	wire signed [24:0] sdSum = {interp_reg[23], interp_reg} + $signed({5'b00000, sdErr_reg});
	wire sdOverflow = (sdSum[24] != sdSum[23]);

	// Divider giving the oversampling enable
	always @(posedge clock)
	begin
		if (rst | ~powerOn)
		begin
			osrCount_reg <= 8'h00;
			osrTick_reg <= 1'b0;
		end
		else
		begin
			osrTick_reg <= (osrCount_reg == `DPG_OSR_DIV - 8'h01);
			osrCount_reg <= (osrCount_reg == `DPG_OSR_DIV - 8'h01) ? 8'h00 : osrCount_reg + 8'h01;
		end
	end

	// 24-bit smoothing interpolator and first-order multi-bit modulator
	always @(posedge clock)
	begin
		if (rst | ~powerOn)
		begin
			interp_reg <= 24'sd0;
			sdErr_reg <= 20'h0_0000;
			modCode_reg <= 4'h0;
			modStrobe_reg <= 1'b0;
			converterActive_reg <= 1'b0;
		end
		else
		begin
			converterActive_reg <= 1'b1;
			modStrobe_reg <= osrTick_reg;
			if (osrTick_reg)
			begin
				interp_reg <= interpSum[23:0];
				sdErr_reg <= sdOverflow ? 20'hF_FFFF : sdSum[`DPG_SD_FRAC - 1:0];
				modCode_reg <= sdOverflow ? 4'h7 : sdSum[23:`DPG_SD_FRAC];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign modCode = modCode_reg;
	assign modStrobe = modStrobe_reg;
	assign analogMute = analogMute_reg;
	assign converterActive = converterActive_reg;

endmodule

// file: test/dpg_gain_checker.sv
// Port-level assertions for the playback gain path.
// Assumes APB3 with one wait state and a synchronous active-high reset.
`timescale 1ns/1ps
module dpg_gain_checker
(
	input wire clock,
	input wire rst,
	input wire [7:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire [23:0] playbackSerialIn,
	input wire playbackSerialValid,
	input wire [3:0] modCode,
	input wire modStrobe,
	input wire analogMute,
	input wire converterActive
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	a_ready_after_setup: assert property ((psel && !penable) |-> ##2 pready) else $error("pready late");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000) else $error("prdata not idle");
	a_misalign_err: assert property ((psel && penable && pready && paddr[1:0] != 2'b00) |-> pslverr)
		else $error("misaligned accepted");
	a_upper_zero: assert property ((pready && !pwrite) |-> prdata[31:24] == 8'h00) else $error("upper bits set");
	a_off_quiet: assert property (!converterActive |-> (!modStrobe && modCode == 4'h0))
		else $error("output while off");
	a_strobe_gap: assert property (modStrobe |=> (!modStrobe)[*8]) else $error("strobes too close");
	a_mute_release: assert property ((analogMute && converterActive && playbackSerialValid &&
		playbackSerialIn != 24'h00_0000) |=> !analogMute) else $error("mute not released");
	a_mute_cause: assert property ($rose(analogMute) |->
		($past(playbackSerialValid) && $past(playbackSerialIn) == 24'h00_0000)) else $error("mute without zero");
endmodule

bind dpg_playback_gain_limiter dpg_gain_checker u_chk (.clock(clock), .rst(rst), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.playbackSerialIn(playbackSerialIn), .playbackSerialValid(playbackSerialValid), .modCode(modCode),
	.modStrobe(modStrobe), .analogMute(analogMute), .converterActive(converterActive));

// file: test/dpg_sample_source.sv
// Host-side sample source: one playback word every PERIOD clocks while run is high.
// Assumes the same clock as the playback path.
`timescale 1ns/1ps
module dpg_sample_source
#(
	parameter PERIOD = 8
)
(
	input wire clock,
	input wire rst,
	input wire run,
	input wire [23:0] value,
	output reg [23:0] sampleData,
	output reg sampleValid
);
	reg [7:0] cntReg;
	// Word with a one-cycle valid; between words the bus shows a changing pattern
	always @(posedge clock)
	begin
		sampleValid <= 1'b0;
		sampleData <= ~sampleData;
		cntReg <= cntReg + 8'h01;
		if (rst || !run)
			cntReg <= 8'h00;
		else if (cntReg == PERIOD - 1)
		begin
			cntReg <= 8'h00;
			sampleValid <= 1'b1;
			sampleData <= value;
		end
	end
	initial
	begin
		sampleData = 24'h5A_5A5A;
		sampleValid = 1'b0;
		cntReg = 8'h00;
	end
endmodule

// file: test/dpg_playback_gain_limiter_tb.sv
// Self-checking bench for the playback gain path: registers over APB, samples from the source model.
// Assumes the design header is on the include path.
`timescale 1ns/1ps
`include "dpg_consts.vh"
module dpg_playback_gain_limiter_tb;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic run = 1'b0;
	logic [23:0] value = 24'h00_0000;
	wire [31:0] prdata;
	wire pready;
	wire pslverr;
	wire [23:0] playbackSerialIn;
	wire playbackSerialValid;
	wire [3:0] modCode;
	wire modStrobe;
	wire analogMute;
	wire converterActive;
	int n_fail = 0;
	int num_checks = 0;
	int cycles = 0;
	logic [31:0] rd;
	logic er;
	logic [31:0] seed = 32'h671c;
	logic [7:0] addrTab [5] = '{{`DPG_IDX_POWER, 2'b00}, {`DPG_IDX_CTRL, 2'b00}, {`DPG_IDX_LEVEL, 2'b00},
		{`DPG_IDX_LIM_A, 2'b00}, {`DPG_IDX_LIM_B, 2'b00}};
	logic [8:0] rstTab [5] = '{`DPG_RST_POWER, `DPG_RST_CTRL, `DPG_RST_LEVEL, `DPG_RST_LIM_A, `DPG_RST_LIM_B};
	logic [8:0] maskTab [5] = '{9'h001, 9'h045, 9'h0FF, 9'h1FF, 9'h07F};

	always #4 clock = ~clock;

	dpg_playback_gain_limiter dut (.clock(clock), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.playbackSerialIn(playbackSerialIn), .playbackSerialValid(playbackSerialValid), .modCode(modCode),
		.modStrobe(modStrobe), .analogMute(analogMute), .converterActive(converterActive));
	dpg_sample_source src (.clock(clock), .rst(rst), .run(run), .value(value),
		.sampleData(playbackSerialIn), .sampleValid(playbackSerialValid));

	////////////////////////////////////////////////////////////////////////////////
	// Pseudo-random source
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Expected sum of 32 modulator codes for an amplitude at a level code, half-dB per code
	function automatic int code_sum(input int amp, input int lvl);
		code_sum = int'(32.0 * amp * (10.0 ** ((lvl - 255) / 40.0)) / 1048576.0);
	endfunction
	// Compare and count
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// One APB transfer; response taken at the edge where pready is high
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1)
			@(posedge clock);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Wait for n sample edges, then let the edge settle
	task wait_samples(input int n);
		repeat (n)
		begin
			@(posedge clock);
			while (playbackSerialValid !== 1'b1)
				@(posedge clock);
		end
		#1;
	endtask
	// Sum of modulator codes over 32 strobes after 64 settling strobes
	task measure(output int s);
		int i;
		s = 0;
		i = 0;
		while (i < 96)
		begin
			@(posedge clock);
			if (modStrobe === 1'b1)
			begin
				if (i >= 64)
					s += $signed(modCode);
				i++;
			end
		end
	endtask
	task print_verdict;
		if (n_fail == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Hang guard
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 90000)
		begin
			n_fail++;
			print_verdict;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		int i, s0, s1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		for (i = 0; i < 5; i++)
		begin
			apb(1'b0, addrTab[i], 32'h0000_0000);
			chk(rd, {23'h0, rstTab[i]});
		end
		apb(1'b0, 8'h10, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		chk(er, 1'b1);
		apb(1'b1, 8'h2D, 32'h0000_0000);
		chk(er, 1'b1);
		apb(1'b1, 8'h7C, 32'hFFFF_FFFF);
		chk(er, 1'b0);
		for (i = 0; i < 8; i++)
		begin
			seed = lfsr_next(seed);
			apb(1'b1, addrTab[i % 4 + 1], seed);
			apb(1'b0, addrTab[i % 4 + 1], 32'h0000_0000);
			chk(rd[8:0] & maskTab[i % 4 + 1], seed[8:0] & maskTab[i % 4 + 1]);
		end
		apb(1'b1, 8'h28, 32'h0000_0000);
		apb(1'b1, 8'h2C, 32'h0000_00FF);
		apb(1'b1, 8'h60, 32'h0000_0000);
		apb(1'b1, 8'h64, 32'h0000_0000);
		apb(1'b1, 8'h0C, 32'h0000_0001);
		value <= 24'h40_0000;
		run <= 1'b1;
		measure(s0);
		chk(s0 > 8, 1'b1);
		chk(s0 >= code_sum(24'h40_0000, 255) - 8 && s0 <= code_sum(24'h40_0000, 255) + 2, 1'b1);
		apb(1'b1, 8'h28, 32'h0000_0001);
		measure(s1);
		chk(s1 < -8 && s1 <= 8 - code_sum(24'h40_0000, 255), 1'b1);
		apb(1'b1, 8'h28, 32'h0000_0000);
		apb(1'b1, 8'h2C, 32'h0000_0000);
		measure(s0);
		chk(s0 <= 4 && s0 >= -4, 1'b1);
		apb(1'b1, 8'h2C, 32'h0000_00F3);
		measure(s0);
		chk(s0 >= code_sum(24'h40_0000, 8'hF3) - 4 && s0 <= code_sum(24'h40_0000, 8'hF3) + 4, 1'b1);
		apb(1'b1, 8'h2C, 32'h0000_00FF);
		value <= 24'h20_0000;
		measure(s0);
		apb(1'b1, 8'h64, 32'h0000_000C);
		measure(s1);
		chk(s0 > 0 && s1 > 2 * s0 + 4, 1'b1);
		apb(1'b1, 8'h28, 32'h0000_0040);
		wait_samples(10);
		apb(1'b0, 8'h7C, 32'h0000_0000);
		chk(rd[23:16] >= 9 && rd[23:16] <= 12, 1'b1);
		wait_samples(260);
		apb(1'b0, 8'h7C, 32'h0000_0000);
		chk(rd[23:16], 8'hFF);
		apb(1'b1, 8'h28, 32'h0000_0000);
		wait_samples(260);
		apb(1'b0, 8'h7C, 32'h0000_0000);
		chk(rd[23:16], 8'h00);
		apb(1'b1, 8'h28, 32'h0000_0004);
		wait_samples(1);
		value <= 24'h00_0000;
		wait_samples(1023);
		chk(analogMute, 1'b0);
		wait_samples(1);
		chk(analogMute, 1'b1);
		value <= 24'h00_0001;
		wait_samples(1);
		chk(analogMute, 1'b0);
		apb(1'b1, 8'h28, 32'h0000_0000);
		value <= 24'h7F_FFFF;
		apb(1'b1, 8'h60, 32'h0000_0100);
		wait_samples(100);
		apb(1'b0, 8'h7C, 32'h0000_0000);
		chk(rd[14:8] != 7'h00, 1'b1);
		value <= 24'h01_0000;
		wait_samples(800);
		apb(1'b0, 8'h7C, 32'h0000_0000);
		chk(rd[14:8], 7'h00);
		apb(1'b1, 8'h0C, 32'h0000_0000);
		repeat (3) @(posedge clock);
		chk(converterActive, 1'b0);
		apb(1'b0, 8'h2C, 32'h0000_0000);
		chk(rd, 32'h0000_00FF);
		print_verdict;
	end
endmodule
